// File: include/coproc_port_consts.svh
// Constants for the host coprocessor control port
`ifndef COPROC_PORT_CONSTS_SVH
`define COPROC_PORT_CONSTS_SVH

// Link geometry
`define PC_W 11
`define HP_AW 12
`define HP_DW 8

// Register offsets in the register region of the link
`define OFS_CTRL 12'h069
`define OFS_STAT 12'h06a
`define OFS_PCHI 12'h06b
`define OFS_PCLO 12'h06c

// Control register fields and reset value
`define CTRL_SOFT 0
`define CTRL_PCR 1
`define CTRL_RAM_LOAD_BIT 2
`define CTRL_GO 3
`define CTRL_STOPIE 4
`define CTRL_NOTIE 5
`define CTRL_RST 8'h01
`define CTRL_RST_SOFT 1'b1

// Status register fields
`define STAT_CLRSTOP 0
`define STAT_CLRNOT 1
`define STAT_STOP 4
`define STAT_NOT 5

// Host command registers on APB
`define APB_CMD 12'h000
`define APB_STAT 12'h004
`define CMD_DATA_LSB 0
`define CMD_ADDR_LSB 8
`define CMD_MEM 20
`define CMD_WR 24
`define HST_BUSY 0
`define HST_IRQ 1
`define HST_RD_LSB 8

`endif

// File: include/coproc_port_pkg.sv
// Types shared by both ends of the coprocessor control port
`include "coproc_port_consts.svh"
package coproc_port_pkg;
    typedef struct packed {
        logic notify_ie;
        logic stop_ie;
        logic ram_load;
        logic pc_reset;
        logic soft_reset;
        logic go;
        logic stop_flag;
        logic notify_flag;
        logic [7:0] pc_lo;
        logic [2:0] pc_hi;
        logic [7:0] hold;
        logic [7:0] rdata;
        logic irq;
        logic [15:0] core_rdata;
    } dev_state_t;

    typedef enum logic [2:0] {
        H_IDLE = 3'b001,
        H_STROBE = 3'b010,
        H_CAPTURE = 3'b100
    } host_fsm_t;

    typedef struct packed {
        host_fsm_t fsm;
        logic sel;
        logic wr;
        logic mem;
        logic [11:0] addr;
        logic [7:0] wdata;
        logic [7:0] rd_byte;
        logic [31:0] prdata;
        logic pslverr;
        logic pready;
    } host_state_t;
endpackage : coproc_port_pkg

// File: include/host_port_if.sv
// Byte-wide link between the host controller and the coprocessor port
`timescale 1ns/100ps
`default_nettype none
`include "coproc_port_consts.svh"
interface host_port_if;
    logic sel;
    logic wr;
    logic mem;
    logic [`HP_AW-1:0] addr;
    logic [`HP_DW-1:0] wdata;
    logic [`HP_DW-1:0] rdata;
    logic irq;

    modport dev
    (
        input sel, wr, mem, addr, wdata,
        output rdata, irq
    );

    modport host
    (
        output sel, wr, mem, addr, wdata,
        input rdata, irq
    );
endinterface : host_port_if
`default_nettype wire

// File: design/host_end.sv
// Host controller: APB command registers driving byte accesses on the link
`timescale 1ns/100ps
`default_nettype none
`include "coproc_port_consts.svh"
module host_end
(
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Link to the coprocessor port
    host_port_if.host link
);
    coproc_port_pkg::host_state_t st_ff;
    coproc_port_pkg::host_state_t nxt_st;
    logic setup;
    logic access;

    assign setup = psel & ~penable;
    assign access = psel & penable;

    always_comb
    begin
        nxt_st = st_ff;
        nxt_st.sel = 1'b0;
        nxt_st.pready = 1'b1;
        // Read data and error prepared in setup so they stand in the access phase
        if (setup)
        begin
            nxt_st.pslverr = (paddr != `APB_CMD) && (paddr != `APB_STAT);
            nxt_st.prdata = 32'h0000_0000;
            if (paddr == `APB_STAT)
            begin
                nxt_st.prdata[`HST_BUSY] = st_ff.fsm != coproc_port_pkg::H_IDLE;
                nxt_st.prdata[`HST_IRQ] = link.irq;
                nxt_st.prdata[`HST_RD_LSB +: 8] = st_ff.rd_byte;
            end
        end
        case (st_ff.fsm)
            coproc_port_pkg::H_IDLE:
            begin
                // A command written while busy is dropped; software polls busy first
                if (access && pwrite && paddr == `APB_CMD)
                begin
                    nxt_st.sel = 1'b1;
                    nxt_st.wr = pwdata[`CMD_WR];
                    nxt_st.mem = pwdata[`CMD_MEM];
                    nxt_st.addr = pwdata[`CMD_ADDR_LSB +: 12];
                    nxt_st.wdata = pwdata[`CMD_DATA_LSB +: 8];
                    nxt_st.fsm = coproc_port_pkg::H_STROBE;
                end
            end
            coproc_port_pkg::H_STROBE:
            begin
                nxt_st.fsm = coproc_port_pkg::H_CAPTURE;
            end
            coproc_port_pkg::H_CAPTURE:
            begin
                if (!st_ff.wr)
                begin
                    nxt_st.rd_byte = link.rdata;
                end
                nxt_st.fsm = coproc_port_pkg::H_IDLE;
            end
            default:
            begin
                nxt_st.fsm = coproc_port_pkg::H_IDLE;
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            st_ff <= '{fsm: coproc_port_pkg::H_IDLE, pready: 1'b1, default: '0};
        end
        else
        begin
            st_ff <= nxt_st;
        end
    end

    assign prdata = st_ff.prdata;
    assign pready = st_ff.pready;
    assign pslverr = st_ff.pslverr;
    assign link.sel = st_ff.sel;
    assign link.wr = st_ff.wr;
    assign link.mem = st_ff.mem;
    assign link.addr = st_ff.addr;
    assign link.wdata = st_ff.wdata;
endmodule : host_end
`default_nettype wire

// File: design/coproc_port.sv
// Coprocessor end: control, status, interrupt and code RAM access for the host
//
// The APB interface to the registers and the placing of the registers were left to the implementer.
`timescale 1ns/100ps
`default_nettype none
`include "coproc_port_consts.svh"
// Summary of operation
// - Soft-reset bit holds whole coprocessor in reset
// - PC-reset bit forces PC to load value
// - Program counter and load value 11 bits
// - Writing go yields start pulse after stop
// - Stop instruction halts core, sets stop flag
// - Stop interrupt only when stop enable set
// - Notify sets notify flag, core keeps running
// - Notify interrupt when notify enable set
// - Code RAM access only under a reset; here one write can set RAM-load and clear both reset bits together
// - RAM-load bit hands code RAM to host
// - RAM-load writable only while reset already set
// - Reset bits writable only while RAM-load clear
// - RAM-load clear: host RAM writes ignored
// - RAM-load clear: host RAM reads zero
// - RAM-load set: random byte reads allowed
// - Host writes pairs: even byte, then odd
// - Even write captures byte in holding register
// - Odd write stores holding byte low, new high
// - Host never writes an odd byte count
// - Host writes bytes in ascending address order
// - Clear-stop write clears stop flag, reads zero
module coproc_port
#(
    parameter int PC_W = `PC_W
)
(
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Link from the host
    host_port_if.dev link,
    // Coprocessor core control
    output logic core_soft_reset,
    output logic core_pc_force,
    output logic [PC_W-1:0] core_pc_value,
    output logic core_go,
    // Coprocessor core events
    input wire logic core_stop_evt,
    input wire logic core_notify_evt,
    // Coprocessor core program fetch
    input wire logic [PC_W-1:0] core_fetch_addr,
    output logic [15:0] core_fetch_data
);
    localparam int DEPTH = 1 << PC_W;

    coproc_port_pkg::dev_state_t st_ff;
    coproc_port_pkg::dev_state_t nxt_st;
    // Code RAM kept outside the state record: it is a memory, not control state
    logic [15:0] code_ram [DEPTH];
    logic ram_we;
    logic [PC_W-1:0] ram_waddr;
    logic [15:0] ram_wdata;
    logic [PC_W-1:0] host_word;
    logic [15:0] host_rword;
    logic reg_wr;
    logic reg_rd;
    logic mem_wr;
    logic mem_rd;
    logic in_reset;

    assign host_word = link.addr[PC_W:1];
    assign host_rword = code_ram[host_word];
    assign reg_wr = link.sel & link.wr & ~link.mem;
    assign reg_rd = link.sel & ~link.wr & ~link.mem;
    assign mem_wr = link.sel & link.wr & link.mem;
    assign mem_rd = link.sel & ~link.wr & link.mem;
    assign in_reset = st_ff.pc_reset | st_ff.soft_reset;

    always_comb
    begin
        nxt_st = st_ff;
        nxt_st.go = 1'b0;
        ram_we = 1'b0;
        ram_waddr = host_word;
        ram_wdata = {link.wdata, st_ff.hold};

        // Control register writes
        if (reg_wr && link.addr == `OFS_CTRL)
        begin
            nxt_st.notify_ie = link.wdata[`CTRL_NOTIE];
            nxt_st.stop_ie = link.wdata[`CTRL_STOPIE];
            nxt_st.go = link.wdata[`CTRL_GO];
            // Old reset bits gate RAM-load, so one write can set it and clear both reset bits
            if (in_reset)
            begin
                nxt_st.ram_load = link.wdata[`CTRL_RAM_LOAD_BIT];
            end
            if (!st_ff.ram_load)
            begin
                nxt_st.pc_reset = link.wdata[`CTRL_PCR];
                nxt_st.soft_reset = link.wdata[`CTRL_SOFT];
            end
        end
        if (reg_wr && link.addr == `OFS_PCHI)
        begin
            nxt_st.pc_hi = link.wdata[2:0];
        end
        if (reg_wr && link.addr == `OFS_PCLO)
        begin
            nxt_st.pc_lo = link.wdata;
        end

        // Flags: clear by write or by either reset, a new event wins
        if (in_reset)
        begin
            nxt_st.stop_flag = 1'b0;
            nxt_st.notify_flag = 1'b0;
        end
        if (reg_wr && link.addr == `OFS_STAT)
        begin
            if (link.wdata[`STAT_CLRSTOP])
            begin
                nxt_st.stop_flag = 1'b0;
            end
            if (link.wdata[`STAT_CLRNOT])
            begin
                nxt_st.notify_flag = 1'b0;
            end
        end
        if (core_stop_evt)
        begin
            nxt_st.stop_flag = 1'b1;
        end
        if (core_notify_evt)
        begin
            nxt_st.notify_flag = 1'b1;
        end
        nxt_st.irq = (nxt_st.stop_flag & nxt_st.stop_ie)
            | (nxt_st.notify_flag & nxt_st.notify_ie);

        // Host code RAM writes; the interim word on an even write is left untouched
        if (mem_wr && st_ff.ram_load)
        begin
            if (!link.addr[0])
            begin
                nxt_st.hold = link.wdata;
            end
            else
            begin
                ram_we = 1'b1;
            end
        end

        // Host reads: answer one cycle after the strobe
        if (reg_rd)
        begin
            nxt_st.rdata = 8'h00;
            case (link.addr)
                `OFS_CTRL:
                begin
                    nxt_st.rdata[`CTRL_NOTIE] = st_ff.notify_ie;
                    nxt_st.rdata[`CTRL_STOPIE] = st_ff.stop_ie;
                    nxt_st.rdata[`CTRL_RAM_LOAD_BIT] = st_ff.ram_load;
                    nxt_st.rdata[`CTRL_PCR] = st_ff.pc_reset;
                    nxt_st.rdata[`CTRL_SOFT] = st_ff.soft_reset;
                end
                `OFS_STAT:
                begin
                    // Clear bits always read as zero
                    nxt_st.rdata[`STAT_STOP] = st_ff.stop_flag;
                    nxt_st.rdata[`STAT_NOT] = st_ff.notify_flag;
                end
                `OFS_PCHI:
                begin
                    nxt_st.rdata[2:0] = st_ff.pc_hi;
                end
                `OFS_PCLO:
                begin
                    nxt_st.rdata = st_ff.pc_lo;
                end
                default:
                begin
                    nxt_st.rdata = 8'h00;
                end
            endcase
        end
        if (mem_rd)
        begin
            if (!st_ff.ram_load)
            begin
                nxt_st.rdata = 8'h00;
            end
            else if (link.addr[0])
            begin
                nxt_st.rdata = host_rword[15:8];
            end
            else
            begin
                nxt_st.rdata = host_rword[7:0];
            end
        end

        // Core fetch sees zero while the host owns the RAM
        nxt_st.core_rdata = st_ff.ram_load ? 16'h0000 : code_ram[core_fetch_addr];
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            st_ff <= '{soft_reset: `CTRL_RST_SOFT, default: '0};
        end
        else
        begin
            st_ff <= nxt_st;
        end
    end

    // No reset on the array so it maps onto plain RAM
    always_ff @(posedge pclk)
    begin
        if (ram_we)
        begin
            code_ram[ram_waddr] <= ram_wdata;
        end
    end

    assign link.rdata = st_ff.rdata;
    assign link.irq = st_ff.irq;
    assign core_soft_reset = st_ff.soft_reset;
    assign core_pc_force = st_ff.pc_reset;
    assign core_pc_value = {st_ff.pc_hi, st_ff.pc_lo};
    assign core_go = st_ff.go;
    assign core_fetch_data = st_ff.core_rdata;
endmodule : coproc_port
`default_nettype wire

// File: sim/coproc_port_checker.sv
// Concurrent checks on the host link and the core controls
`timescale 1ns/100ps
`default_nettype none
`include "coproc_port_consts.svh"
module coproc_port_checker
(
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Link
    input wire logic sel,
    input wire logic wr,
    input wire logic mem,
    input wire logic [11:0] addr,
    input wire logic [7:0] wdata,
    input wire logic [7:0] rdata,
    input wire logic irq,
    // Core side
    input wire logic core_soft_reset,
    input wire logic core_pc_force,
    input wire logic core_go,
    input wire logic core_stop_evt,
    input wire logic core_notify_evt,
    input wire logic [15:0] core_fetch_data
);
    // Shadow {notify_ie, stop_ie, ram_load, pc_reset, soft_reset}
    logic [4:0] ctl_ff;
    logic [4:0] nxt_ctl;
    logic cw;
    assign cw = sel && wr && !mem && addr == `OFS_CTRL;
    always_comb
    begin
        nxt_ctl = ctl_ff;
        if (cw)
        begin
            nxt_ctl[4:3] = wdata[5:4];
            if (!ctl_ff[2])
                nxt_ctl[1:0] = wdata[1:0];
            if (ctl_ff[1:0] != 2'h0)
                nxt_ctl[2] = wdata[2];
        end
    end
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            ctl_ff <= 5'h01;
        else
            ctl_ff <= nxt_ctl;
    end
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    AST_GO_PULSE:
        assert property (core_go |=> !core_go) else $error("start pulse too long");
    AST_GO_CAUSE:
        assert property (core_go |-> $past(cw && wdata[`CTRL_GO])) else $error("start pulse without go write");
    AST_SOFT_WR:
        assert property (cw && !ctl_ff[2] |=> core_soft_reset == $past(wdata[0])) else $error("soft reset wrong");
    AST_PCR_CHANGE:
        assert property ($changed(core_pc_force) |-> $past(cw && !ctl_ff[2])) else $error("pc force changed");
    AST_RAM_LOAD_BIT_FETCH:
        assert property (ctl_ff[2] && $past(ctl_ff[2]) |-> core_fetch_data == 16'h0000)
            else $error("core fetch while host owns ram");
    AST_RD_ZERO:
        assert property (sel && !wr && mem && !ctl_ff[2] |=> rdata == 8'h00) else $error("ram read not zero");
    AST_CLR_IRQ:
        assert property (sel && wr && !mem && addr == `OFS_STAT && (wdata[`STAT_CLRSTOP] || !ctl_ff[3])
            && (wdata[`STAT_CLRNOT] || !ctl_ff[4]) && !core_stop_evt && !core_notify_evt |=> !irq)
            else $error("irq not cleared");
    AST_IRQ_MASK:
        assert property (ctl_ff[4:3] == 2'h0 && $past(ctl_ff[4:3]) == 2'h0 |-> !irq) else $error("irq unmasked");
    AST_STOP_IRQ:
        assert property (core_stop_evt && ctl_ff[3] && ctl_ff[1:0] == 2'h0 |=> irq) else $error("no stop irq");
    AST_NOTE_IRQ:
        assert property (core_notify_evt && ctl_ff[4] && ctl_ff[1:0] == 2'h0 |=> irq) else $error("no notify irq");
    AST_IRQ_HOLD:
        assert property (irq && !sel && !core_soft_reset && !core_pc_force |=> irq) else $error("irq dropped alone");
    cover property (core_go);
    cover property (sel && wr && mem && addr[0] && ctl_ff[2]);
    cover property (irq ##1 !irq);
endmodule : coproc_port_checker
`default_nettype wire

// File: sim/host_coprocessor_control_port_tb_top.sv
// Bench joining the host controller and the coprocessor port
`timescale 1ns/100ps
`default_nettype none
`include "coproc_port_consts.svh"
module host_coprocessor_control_port_tb_top;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic core_soft_reset;
    logic core_pc_force;
    logic [10:0] core_pc_value;
    logic core_go;
    logic core_stop_evt = 1'b0;
    logic core_notify_evt = 1'b0;
    logic [10:0] core_fetch_addr = 11'h000;
    logic [15:0] core_fetch_data;
    logic [7:0] rb;
    logic [31:0] s;
    int n_fail = 0;
    int cmp_count = 0;
    int go_seen = 0;
    host_port_if link_if();
    host_end host_end_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .link(link_if));
    coproc_port coproc_port_inst (.pclk(pclk), .presetn(presetn), .link(link_if), .core_go(core_go),
        .core_soft_reset(core_soft_reset), .core_pc_force(core_pc_force), .core_pc_value(core_pc_value),
        .core_stop_evt(core_stop_evt), .core_notify_evt(core_notify_evt), .core_fetch_addr(core_fetch_addr),
        .core_fetch_data(core_fetch_data));
    coproc_port_checker coproc_port_checker_inst (.pclk(pclk), .presetn(presetn), .sel(link_if.sel),
        .wr(link_if.wr), .mem(link_if.mem), .addr(link_if.addr), .wdata(link_if.wdata), .rdata(link_if.rdata),
        .irq(link_if.irq), .core_soft_reset(core_soft_reset), .core_pc_force(core_pc_force), .core_go(core_go),
        .core_stop_evt(core_stop_evt), .core_notify_evt(core_notify_evt), .core_fetch_data(core_fetch_data));
    initial
    begin
        forever #2.5 pclk = ~pclk;
    end
    always @(negedge pclk)
    begin
        if (core_go === 1'b1)
            go_seen++;
    end
    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : print_verdict
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] v);
        cmp_count++;
        if (v !== e)
        begin
            $display("mismatch %s expected %h seen %h", nm, e, v);
            n_fail++;
        end
    endtask : chk
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] r);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge pclk);
            n++;
        end
        while (pready !== 1'b1 && n < 50);
        if (n == 50)
        begin
            n_fail++;
            print_verdict();
        end
        r = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    // One link access through the command register; waits out busy
    task automatic lk(input logic w, input logic m, input logic [11:0] a, input logic [7:0] d);
        int n;
        apb(1'b1, `APB_CMD, {7'h00, w, 3'h0, m, a, d}, s);
        n = 0;
        do
        begin
            apb(1'b0, `APB_STAT, 32'h0, s);
            n++;
        end
        while (s[`HST_BUSY] !== 1'b0 && n < 20);
        if (n == 20)
        begin
            n_fail++;
            print_verdict();
        end
        rb = s[15:8];
        @(negedge pclk);
    endtask : lk
    task automatic rd(input logic m, input logic [11:0] a, input logic [7:0] e);
        lk(1'b0, m, a, 8'h00);
        chk($sformatf("byte %h", a), {24'h0, e}, {24'h0, rb});
    endtask : rd
    task automatic ev(input logic stop);
        @(posedge pclk);
        if (stop)
            core_stop_evt <= 1'b1;
        else
            core_notify_evt <= 1'b1;
        @(posedge pclk);
        core_stop_evt <= 1'b0;
        core_notify_evt <= 1'b0;
        @(negedge pclk);
    endtask : ev
    task automatic t_reset_pc();
        rd(1'b0, `OFS_CTRL, 8'h01);
        chk("soft_reset", 1, core_soft_reset);
        lk(1'b1, 1'b0, `OFS_PCHI, 8'h05);
        lk(1'b1, 1'b0, `OFS_PCLO, 8'ha3);
        lk(1'b1, 1'b0, `OFS_CTRL, 8'h02);
        chk("soft_reset", 0, core_soft_reset);
        chk("pc_force", 1, core_pc_force);
        chk("pc_value", 11'h5a3, core_pc_value);
        $display("test reset_pc done");
    endtask : t_reset_pc
    task automatic t_guard();
        lk(1'b1, 1'b0, `OFS_CTRL, 8'h06);
        rd(1'b0, `OFS_CTRL, 8'h06);
        lk(1'b1, 1'b0, `OFS_CTRL, 8'h00);
        rd(1'b0, `OFS_CTRL, 8'h02);
        lk(1'b1, 1'b0, `OFS_CTRL, 8'h00);
        lk(1'b1, 1'b0, `OFS_CTRL, 8'h04);
        rd(1'b0, `OFS_CTRL, 8'h00);
        $display("test guard done");
    endtask : t_guard
    task automatic t_ram();
        lk(1'b1, 1'b0, `OFS_CTRL, 8'h02);
        lk(1'b1, 1'b0, `OFS_CTRL, 8'h06);
        lk(1'b1, 1'b1, 12'h010, 8'h34);
        lk(1'b1, 1'b1, 12'h011, 8'h12);
        lk(1'b1, 1'b1, 12'h012, 8'h78);
        lk(1'b1, 1'b1, 12'h013, 8'h56);
        rd(1'b1, 12'h013, 8'h56);
        rd(1'b1, 12'h010, 8'h34);
        rd(1'b1, 12'h012, 8'h78);
        rd(1'b1, 12'h011, 8'h12);
        chk("fetch", 0, core_fetch_data);
        lk(1'b1, 1'b0, `OFS_CTRL, 8'h02);
        rd(1'b1, 12'h010, 8'h00);
        lk(1'b1, 1'b1, 12'h010, 8'hab);
        lk(1'b1, 1'b1, 12'h011, 8'hcd);
        @(posedge pclk);
        core_fetch_addr <= 11'h008;
        repeat (2) @(posedge pclk);
        @(negedge pclk);
        chk("fetch", 16'h1234, core_fetch_data);
        $display("test ram done");
    endtask : t_ram
    task automatic t_irq();
        lk(1'b1, 1'b0, `OFS_CTRL, 8'h00);
        lk(1'b1, 1'b0, `OFS_CTRL, 8'h10);
        ev(1'b1);
        rd(1'b0, `OFS_STAT, 8'h10);
        chk("irq", 1, link_if.irq);
        chk("stat irq", 1, s[`HST_IRQ]);
        lk(1'b1, 1'b0, `OFS_STAT, 8'h01);
        rd(1'b0, `OFS_STAT, 8'h00);
        chk("irq", 0, link_if.irq);
        ev(1'b0);
        rd(1'b0, `OFS_STAT, 8'h20);
        chk("irq", 0, link_if.irq);
        lk(1'b1, 1'b0, `OFS_CTRL, 8'h20);
        chk("irq", 1, link_if.irq);
        lk(1'b1, 1'b0, `OFS_STAT, 8'h02);
        chk("irq", 0, link_if.irq);
        ev(1'b0);
        chk("irq", 1, link_if.irq);
        lk(1'b1, 1'b0, `OFS_STAT, 8'h02);
        chk("irq", 0, link_if.irq);
        ev(1'b1);
        rd(1'b0, `OFS_STAT, 8'h10);
        chk("irq", 0, link_if.irq);
        lk(1'b1, 1'b0, `OFS_CTRL, 8'h01);
        rd(1'b0, `OFS_STAT, 8'h00);
        $display("test irq done");
    endtask : t_irq
    task automatic t_go_err();
        lk(1'b1, 1'b0, `OFS_CTRL, 8'h08);
        rd(1'b0, `OFS_CTRL, 8'h00);
        chk("go pulses", 1, go_seen);
        apb(1'b0, 12'h008, 32'h0, s);
        chk("pslverr", 1, pslverr);
        chk("prdata", 0, s);
        $display("test go_err done");
    endtask : t_go_err
    initial
    begin
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        t_reset_pc();
        t_guard();
        t_ram();
        t_irq();
        t_go_err();
        print_verdict();
    end
endmodule : host_coprocessor_control_port_tb_top
`default_nettype wire
